// ### cisv_pkg.sv
/*
 * cisv_pkg: constants and carrier types for the core interrupt status and
 * vectoring block. Assumes a 32-bit AXI4-Lite register bus and a core that
 * accepts one vector request at a time.
 */
package cisv_pkg;
    // register addresses: core data address, then byte addresses on the bus
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h07; // core data address of the register
    localparam logic [11:0] OFF_STATUS_CONTROL = 12'h01c; // byte address, index 07h times four
    localparam logic [11:0] OFF_PERIPH_FLAGS = 12'h020; // peripheral request flags
    localparam logic [11:0] OFF_PERIPH_ENABLES = 12'h024; // peripheral enables
    localparam logic [11:0] OFF_GLOBAL_CTRL = 12'h028; // global disable, bit 0
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h02c; // sticky events, cleared on read
    localparam logic [11:0] OFF_IRQ_MASK = 12'h030; // mask for irq output
    // field positions inside the status/control byte
    localparam int BIT_PERIPH_FLAG = 7;
    localparam int BIT_TCLK_FLAG = 6;
    localparam int BIT_TZERO_FLAG = 5;
    localparam int BIT_EXT_FLAG = 4;
    localparam int BIT_PERIPH_EN = 3;
    localparam int BIT_TCLK_EN = 2;
    localparam int BIT_TZERO_EN = 1;
    localparam int BIT_EXT_EN = 0;
    // reset values
    localparam logic [7:0] RST_STATUS_CONTROL = 8'h00;
    localparam logic RST_GLOBAL_DISABLE = 1'b1;
    // fixed program-memory vectors
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_EXT_PIN = 16'h0008;
    localparam logic [15:0] VEC_TZERO = 16'h0010;
    localparam logic [15:0] VEC_TCLK_PIN = 16'h0018;
    localparam logic [15:0] VEC_PERIPH = 16'h0020;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // vector request to the core
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } cisv_vec_s;

    // sources in service order
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_RESET,
        SRC_EXT,
        SRC_TZERO,
        SRC_TCLK,
        SRC_PERIPH
    } cisv_src_e;
endpackage : cisv_pkg

// ### cisv_vec_pick.sv
/*
 * cisv_vec_pick: fixed-priority selection of one pending source and its
 * vector address. Assumes pending inputs are already gated by enables.
 */
`timescale 1ns/1ps
`default_nettype none
module cisv_vec_pick (
    // pending sources, gated
    input wire logic ext_req,
    input wire logic tzero_req,
    input wire logic tclk_req,
    input wire logic periph_req,
    input wire logic reset_req,
    // chosen vector
    output cisv_pkg::cisv_src_e src,
    output logic [15:0] addr
);
    import cisv_pkg::*;

    // lowest vector wins; the spurious reset case outranks all
    always_comb begin
        src = SRC_NONE;
        addr = VEC_RESET;
        if (reset_req) begin
            src = SRC_RESET;
            addr = VEC_RESET;
        end else if (ext_req) begin
            src = SRC_EXT;
            addr = VEC_EXT_PIN;
        end else if (tzero_req) begin
            src = SRC_TZERO;
            addr = VEC_TZERO;
        end else if (tclk_req) begin
            src = SRC_TCLK;
            addr = VEC_TCLK_PIN;
        end else if (periph_req) begin
            src = SRC_PERIPH;
            addr = VEC_PERIPH;
        end
    end
endmodule : cisv_vec_pick
`default_nettype wire

// ### cisv_core_irq.sv
/*
 * cisv_core_irq: interrupt status/control register and vectoring for an
 * 8-bit core. Assumes edge and overflow events arrive as one-cycle pulses,
 * synchronous to clk, one instruction cycle per clock; the core accepts a
 * vector with vec_ack and then starts at vec.addr.
 */
// Overview of operation
// - status/control byte at data address 07h
// - bit 7 is OR of enabled peripheral flags
// - flags set regardless of enables or disable
// - flag set while enable cleared vectors reset, unless globally disabled
// - bit 6 timer-pin edge, cleared at 18h
// - bit 5 timer overflow, cleared at 10h
// - bit 4 external pin edge, cleared at 08h
// - bit 3 gates all peripheral requests
// - bit 2 enables timer-pin edge interrupt
// - bit 1 enables timer overflow interrupt
// - bit 0 enables external pin interrupt
// - reset at 0000h, fixed vectors 08h to 20h
`timescale 1ns/1ps
`default_nettype none
module cisv_core_irq #(
    parameter int PERIPH_N = 8 // number of peripheral request lines
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // event pulses
    input wire logic ext_pin_edge,
    input wire logic tclk_pin_edge,
    input wire logic tzero_overflow,
    input wire logic [PERIPH_N-1:0] periph_event,
    // vector handshake with the core
    input wire logic vec_ack,
    output cisv_pkg::cisv_vec_s vec,
    // interrupt to the system
    output logic irq,
    // axi4-lite write address
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    // axi4-lite write data
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // axi4-lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read address
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    // axi4-lite read data
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    import cisv_pkg::*;

    logic [3:0] flags_r; // ext, tzero, tclk in 0..2; bit 3 unused
    logic [3:0] enables_r; // byte bits 3..0
    logic global_disable_r; // ext, timer and peripheral vector requests off when set; irq is not gated
    logic [PERIPH_N-1:0] pflags_r; // peripheral request flags
    logic [PERIPH_N-1:0] pen_r; // peripheral enables
    logic [3:0] evstat_r; // sticky: vector taken, reset vector, ext, tzero
    logic [3:0] evmask_r; // irq mask
    logic [11:0] awaddr_r; // latched write address
    logic aw_have_r; // write address held
    logic [31:0] wdata_r; // latched write data
    logic [3:0] wstrb_r; // latched strobes
    logic w_have_r; // write data held
    logic wr_go; // both halves present
    logic rd_go; // read taken this cycle
    logic wr_status; // write to the status/control byte this cycle
    logic vec_taken; // core accepts the standing vector
    logic periph_flag; // bit 7
    logic [7:0] byte_now; // assembled status/control byte
    logic [3:0] en_clear; // enables falling on this write
    logic [3:0] set_now; // flag sources this cycle, byte bit order 4..7
    logic race; // flag set while its enable drops
    logic race_r; // latched spurious-reset request
    cisv_src_e pick_src; // chosen source
    logic [15:0] pick_addr; // chosen vector
    logic [31:0] rdata_nxt; // read mux

    // bit 7 is never stored, only computed
    assign periph_flag = |(pflags_r & pen_r);
    assign byte_now = {periph_flag, flags_r[2], flags_r[1], flags_r[0], enables_r};
    assign wr_go = aw_have_r && w_have_r && !s_bvalid;
    assign rd_go = s_arvalid && s_arready;

    // byte write to the status/control register hits only its low lane
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction : hit

    // vector that serves source flag i: ext, tzero, tclk
    function automatic logic [15:0] flag_vec(input int i);
        flag_vec = (i == 0) ? VEC_EXT_PIN : (i == 1) ? VEC_TZERO : VEC_TCLK_PIN;
    endfunction : flag_vec

    assign wr_status = wr_go && hit(awaddr_r, OFF_STATUS_CONTROL) && wstrb_r[0];
    assign vec_taken = vec.valid && vec_ack;

    assign en_clear = (wr_go && hit(awaddr_r, OFF_STATUS_CONTROL) && wstrb_r[0])
                      ? (enables_r & ~wdata_r[3:0]) : 4'h0;
    // event sources in byte order: ext(4), tzero(5), tclk(6), periph(7)
    assign set_now = {|periph_event, tclk_pin_edge, tzero_overflow, ext_pin_edge};
    // enable bits that match: ext->0, tzero->1, tclk->2, periph->3
    assign race = !global_disable_r && |(set_now & en_clear);

    // write channel capture, either order accepted
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_awaddr;
            end else if (wr_go) begin
                aw_have_r <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_have_r <= 1'b1;
                wdata_r <= s_wdata;
                wstrb_r <= s_wstrb;
            end else if (wr_go) begin
                w_have_r <= 1'b0;
            end
        end
    end

    // ready flags registered so outputs come from flops
    always_ff @(posedge clk) begin
        if (rst) begin
            s_awready <= 1'b0;
            s_wready <= 1'b0;
        end else begin
            s_awready <= !aw_have_r && !(s_awvalid && s_awready);
            s_wready <= !w_have_r && !(s_wvalid && s_wready);
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge clk) begin
        if (rst) begin
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_bvalid <= 1'b1;
            s_bresp <= (hit(awaddr_r, OFF_STATUS_CONTROL) || hit(awaddr_r, OFF_PERIPH_FLAGS)
                        || hit(awaddr_r, OFF_PERIPH_ENABLES) || hit(awaddr_r, OFF_GLOBAL_CTRL)
                        || hit(awaddr_r, OFF_IRQ_STATUS) || hit(awaddr_r, OFF_IRQ_MASK))
                       ? RESP_OKAY : RESP_SLVERR;
        end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // source flags: events set, vectoring clears, software may write 0/1
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r <= RST_STATUS_CONTROL[7:4];
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (set_now[i]) begin
                    flags_r[i] <= 1'b1;
                end else if (wr_status) begin
                    flags_r[i] <= wdata_r[4 + i];
                end else if (vec_taken && vec.addr == flag_vec(i)) begin
                    // hardware clear on taking its vector
                    flags_r[i] <= 1'b0;
                end
            end
            flags_r[3] <= 1'b0;
        end
    end

    // enables and global disable, written by software
    always_ff @(posedge clk) begin
        if (rst) begin
            enables_r <= RST_STATUS_CONTROL[3:0];
            global_disable_r <= RST_GLOBAL_DISABLE;
        end else if (wr_go) begin
            if (hit(awaddr_r, OFF_STATUS_CONTROL) && wstrb_r[0]) begin
                enables_r <= wdata_r[3:0];
            end
            if (hit(awaddr_r, OFF_GLOBAL_CTRL) && wstrb_r[0]) begin
                global_disable_r <= wdata_r[0];
            end
        end
    end

    // peripheral flags: events set, software clears by writing 0
    always_ff @(posedge clk) begin
        if (rst) begin
            pflags_r <= '0;
            pen_r <= '0;
        end else begin
            for (int i = 0; i < PERIPH_N; i++) begin
                if (periph_event[i]) begin
                    pflags_r[i] <= 1'b1;
                end else if (wr_go && hit(awaddr_r, OFF_PERIPH_FLAGS)) begin
                    pflags_r[i] <= wdata_r[i];
                end
            end
            if (wr_go && hit(awaddr_r, OFF_PERIPH_ENABLES)) begin
                pen_r <= wdata_r[PERIPH_N-1:0];
            end
        end
    end

    // the odd race is remembered until the core takes the reset vector
    always_ff @(posedge clk) begin
        if (rst) begin
            race_r <= 1'b0;
        end else if (race) begin
            race_r <= 1'b1;
        end else if (vec_taken && vec.addr == VEC_RESET) begin
            race_r <= 1'b0;
        end
    end

    cisv_vec_pick u_pick (
        .ext_req(!global_disable_r && flags_r[0] && enables_r[BIT_EXT_EN]),
        .tzero_req(!global_disable_r && flags_r[1] && enables_r[BIT_TZERO_EN]),
        .tclk_req(!global_disable_r && flags_r[2] && enables_r[BIT_TCLK_EN]),
        .periph_req(!global_disable_r && periph_flag && enables_r[BIT_PERIPH_EN]),
        .reset_req(race_r),
        .src(pick_src),
        .addr(pick_addr)
    );

    // vector request re-picked every cycle until acknowledged; a fresh pick follows the ack
    always_ff @(posedge clk) begin
        if (rst) begin
            vec <= '{valid: 1'b0, addr: VEC_RESET};
        end else if (vec.valid && vec_ack) begin
            vec.valid <= 1'b0;
        end else begin
            vec.valid <= (pick_src != SRC_NONE);
            vec.addr <= pick_addr;
        end
    end

    // read mux
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit(s_araddr, OFF_STATUS_CONTROL)) begin
            rdata_nxt[7:0] = byte_now;
        end else if (hit(s_araddr, OFF_PERIPH_FLAGS)) begin
            rdata_nxt[PERIPH_N-1:0] = pflags_r;
        end else if (hit(s_araddr, OFF_PERIPH_ENABLES)) begin
            rdata_nxt[PERIPH_N-1:0] = pen_r;
        end else if (hit(s_araddr, OFF_GLOBAL_CTRL)) begin
            rdata_nxt[0] = global_disable_r;
        end else if (hit(s_araddr, OFF_IRQ_STATUS)) begin
            rdata_nxt[3:0] = evstat_r;
        end else if (hit(s_araddr, OFF_IRQ_MASK)) begin
            rdata_nxt[3:0] = evmask_r;
        end
    end

    // read channel: one read at a time, answer the cycle after acceptance
    always_ff @(posedge clk) begin
        if (rst) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= RESP_OKAY;
        end else begin
            s_arready <= !s_rvalid && !rd_go;
            if (rd_go) begin
                s_rvalid <= 1'b1;
                s_rdata <= rdata_nxt;
                s_rresp <= (hit(s_araddr, OFF_STATUS_CONTROL) || hit(s_araddr, OFF_PERIPH_FLAGS)
                            || hit(s_araddr, OFF_PERIPH_ENABLES) || hit(s_araddr, OFF_GLOBAL_CTRL)
                            || hit(s_araddr, OFF_IRQ_STATUS) || hit(s_araddr, OFF_IRQ_MASK))
                           ? RESP_OKAY : RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // sticky events; set beats the clear-on-read
    always_ff @(posedge clk) begin
        if (rst) begin
            evstat_r <= 4'h0;
            evmask_r <= 4'h0;
        end else begin
            evstat_r <= ((rd_go && hit(s_araddr, OFF_IRQ_STATUS)) ? 4'h0 : evstat_r)
                        | {tzero_overflow, ext_pin_edge, race, vec.valid && vec_ack};
            if (wr_go && hit(awaddr_r, OFF_IRQ_MASK)) begin
                evmask_r <= wdata_r[3:0];
            end
        end
    end

    // level irq from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evstat_r & evmask_r);
        end
    end

    // spurious reset vector is offered while latched
    race_vec_a: assert property (@(posedge clk) disable iff (rst)
        race |=> ##[1:3] (vec.valid && vec.addr == VEC_RESET))
        else $error("race did not reach reset vector");
    flag_set_a: assert property (@(posedge clk) disable iff (rst)
        ext_pin_edge |=> flags_r[0])
        else $error("ext flag not set");
    pflag_or_a: assert property (@(posedge clk) disable iff (rst)
        byte_now[BIT_PERIPH_FLAG] == |(pflags_r & pen_r))
        else $error("periph flag wrong");
    ext_clear_a: assert property (@(posedge clk) disable iff (rst)
        (vec.valid && vec_ack && vec.addr == VEC_EXT_PIN && !ext_pin_edge && !wr_go)
        |=> !flags_r[0])
        else $error("ext flag not cleared");
    tzero_clear_a: assert property (@(posedge clk) disable iff (rst)
        (vec.valid && vec_ack && vec.addr == VEC_TZERO && !tzero_overflow && !wr_go)
        |=> !flags_r[1])
        else $error("overflow flag not cleared");
    tclk_clear_a: assert property (@(posedge clk) disable iff (rst)
        (vec.valid && vec_ack && vec.addr == VEC_TCLK_PIN && !tclk_pin_edge && !wr_go)
        |=> !flags_r[2])
        else $error("timer pin flag not cleared");
    gated_req_a: assert property (@(posedge clk) disable iff (rst)
        $rose(vec.valid) && vec.addr != VEC_RESET |-> !$past(global_disable_r))
        else $error("vector while disabled");
    periph_block_a: assert property (@(posedge clk) disable iff (rst)
        (vec.valid && vec.addr == VEC_PERIPH && $rose(vec.valid)) |-> $past(enables_r[3]))
        else $error("peripheral vector while blocked");
    ext_en_a: assert property (@(posedge clk) disable iff (rst)
        ($rose(vec.valid) && vec.addr == VEC_EXT_PIN) |-> $past(enables_r[0]))
        else $error("ext vector while disabled");
    tzero_en_a: assert property (@(posedge clk) disable iff (rst)
        ($rose(vec.valid) && vec.addr == VEC_TZERO) |-> $past(enables_r[1]))
        else $error("overflow vector while disabled");
    tclk_en_a: assert property (@(posedge clk) disable iff (rst)
        ($rose(vec.valid) && vec.addr == VEC_TCLK_PIN) |-> $past(enables_r[2]))
        else $error("timer pin vector while disabled");
    reg_read_a: assert property (@(posedge clk) disable iff (rst)
        (rd_go && hit(s_araddr, OFF_STATUS_CONTROL)) |=> s_rdata[7:0] == $past(byte_now))
        else $error("status byte read wrong");
    vec_cover_c: cover property (@(posedge clk) vec.valid && vec_ack);
    race_cover_c: cover property (@(posedge clk) race);
    irq_cover_c: cover property (@(posedge clk) irq);
endmodule : cisv_core_irq
`default_nettype wire

// ### cisv_cpu_model.sv
/*
 * cisv_cpu_model: core side that accepts vector requests from the block.
 * Assumes vec stays up until vec_ack, and that the bench paces it with hold and lat.
 */
`timescale 1ns/1ps
`default_nettype none
module cisv_cpu_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // vector request and acceptance
    input wire cisv_pkg::cisv_vec_s vec,
    output logic vec_ack,
    // pacing from the bench
    input wire logic hold,
    input wire logic [1:0] lat
);
    import cisv_pkg::*;
    logic [1:0] wait_r; // cycles the request has stood

    // accept after lat cycles; hold keeps a request standing on purpose
    always_ff @(posedge clk) begin
        if (rst || vec_ack) begin
            vec_ack <= 1'b0;
            wait_r <= 2'h0;
        end else if (vec.valid && !hold && wait_r >= lat) begin
            vec_ack <= 1'b1; // one-cycle pulse, valid drops next cycle
        end else if (vec.valid && wait_r != 2'h3) begin
            wait_r <= wait_r + 2'h1; // saturate so a held request cannot wrap
        end
    end
endmodule : cisv_cpu_model
`default_nettype wire

// ### tb_core_interrupt_status_vectoring.sv
/*
 * tb_core_interrupt_status_vectoring: self-checking bench for cisv_core_irq.
 * Assumes registered axi4-lite outputs and the core model cisv_cpu_model.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_core_interrupt_status_vectoring;
    import cisv_pkg::*;
    logic clk, rst, ext, tclk, tz, ack, irq, hold, sweep, seen;
    logic [7:0] pev; // peripheral event pulses
    logic [1:0] lat; // core acceptance delay
    cisv_vec_s vec;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [33:0] rq[$], bq[$], vq[$]; // expected results, oldest first
    int error_cnt, samples_checked, p;

    // free-running 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    cisv_core_irq #(.PERIPH_N(8)) u_cisv_core_irq (
        .clk(clk), .rst(rst), .ext_pin_edge(ext), .tclk_pin_edge(tclk),
        .tzero_overflow(tz), .periph_event(pev), .vec_ack(ack), .vec(vec), .irq(irq),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
        .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
        .s_bvalid(bvalid), .s_bready(1'b1), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
        .s_rready(1'b1));

    cisv_cpu_model u_cisv_cpu_model (
        .clk(clk), .rst(rst), .vec(vec), .vec_ack(ack), .hold(hold), .lat(lat));

    task automatic chk(input string what, input logic [33:0] seen_v, input logic [33:0] exp);
        samples_checked++;
        if (seen_v !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen_v);
        end
    endtask : chk

    task automatic stop_test;
        if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        bq.push_back({32'h0, r});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
    endtask : wr

    // read: the answer is compared by the monitor
    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        rq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
    endtask : rd

    // one-cycle event pulses, then one edge so the flags land
    task automatic pulse(input logic [2:0] s, input logic [7:0] pe);
        {tclk, tz, ext} <= s;
        pev <= pe;
        @(posedge clk);
        {tclk, tz, ext} <= 3'b000;
        pev <= 8'h0;
        @(posedge clk);
    endtask : pulse

    // wait until every expected vector was accepted
    task automatic drain;
        while (vq.size() != 0) @(posedge clk);
        @(posedge clk);
    endtask : drain

    // monitor: an unexpected result meets an unknown note and fails
    always @(posedge clk) begin
        if (rvalid) chk("rdata", {rresp, rdata}, rq.size() ? rq.pop_front() : 'x);
        if (bvalid) chk("bresp", {32'h0, bresp}, bq.size() ? bq.pop_front() : 'x);
        if (vec.valid && ack && !sweep)
            chk("vector", {18'h0, vec.addr}, vq.size() ? vq.pop_front() : 'x);
    end

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        stop_test();
    end

    initial begin
        {rst, ext, tclk, tz, hold, sweep, seen} = 7'h40;
        {awvalid, wvalid, arvalid} = 3'b000;
        {awaddr, araddr, wdata, pev, lat} = '0;
        error_cnt = 0;
        samples_checked = 0;
        void'($urandom(32'hc994349e));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("vec", {17'h0, vec}, {17'h0, 1'b0, VEC_RESET});
        chk("irq", {33'h0, irq}, 34'h0);
        rd(OFF_STATUS_CONTROL, 32'h0);
        rd(OFF_GLOBAL_CTRL, 32'h1);
        rd(OFF_IRQ_MASK, 32'h0);
        rd(12'h100, 32'h0, RESP_SLVERR);
        wr(12'h104, 32'hff, RESP_SLVERR);
        // events land while everything is disabled
        pulse(3'b111, 8'h0);
        rd(OFF_STATUS_CONTROL, 32'h70);
        chk("irq masked", {33'h0, irq}, 34'h0);
        rd(OFF_IRQ_STATUS, 32'h0c);
        rd(OFF_IRQ_STATUS, 32'h0);
        // three pending at once: lowest vector first, flags cleared as served
        lat <= 2'($urandom_range(0, 3));
        wr(OFF_IRQ_MASK, 32'h1);
        wr(OFF_STATUS_CONTROL, 32'h77);
        vq = '{34'h8, 34'h10, 34'h18};
        wr(OFF_GLOBAL_CTRL, 32'h0);
        drain();
        rd(OFF_STATUS_CONTROL, 32'h07);
        chk("irq", {33'h0, irq}, 34'h1);
        rd(OFF_IRQ_STATUS, 32'h01);
        repeat (2) @(posedge clk);
        chk("irq cleared", {33'h0, irq}, 34'h0);
        // one enable at a time: only its source vectors
        for (int i = 0; i < 3; i++) begin
            lat <= 2'($urandom_range(0, 3));
            wr(OFF_GLOBAL_CTRL, 32'h1);
            wr(OFF_STATUS_CONTROL, 32'h1 << i);
            wr(OFF_GLOBAL_CTRL, 32'h0);
            vq.push_back(34'(8 * (i + 1)));
            pulse(3'b111, 8'h0);
            drain();
            rd(OFF_STATUS_CONTROL, (32'h70 & ~(32'h10 << i)) | (32'h1 << i));
        end
        // peripheral flag is gated by its own enable, its vector also by the group enable
        p = $urandom_range(0, 7);
        wr(OFF_GLOBAL_CTRL, 32'h1);
        wr(OFF_STATUS_CONTROL, 32'h0);
        wr(OFF_PERIPH_ENABLES, 32'h1 << p);
        pulse(3'b000, 8'h1 << ((p + 1) % 8));
        rd(OFF_STATUS_CONTROL, 32'h00);
        pulse(3'b000, 8'h1 << p);
        rd(OFF_STATUS_CONTROL, 32'h80);
        wr(OFF_STATUS_CONTROL, 32'h0);
        rd(OFF_STATUS_CONTROL, 32'h80);
        wr(OFF_GLOBAL_CTRL, 32'h0);
        repeat (4) @(posedge clk);
        hold <= 1'b1;
        wr(OFF_STATUS_CONTROL, 32'h08);
        while (!vec.valid) @(posedge clk);
        chk("periph vec", {18'h0, vec.addr}, {18'h0, VEC_PERIPH});
        vq.push_back({18'h0, VEC_PERIPH});
        hold <= 1'b0;
        // hold again right after the acceptance: the peripheral flag stays set
        while (!ack) @(posedge clk);
        hold <= 1'b1;
        drain();
        wr(OFF_GLOBAL_CTRL, 32'h1);
        // clear an enable while its event fires: sweep the event over the write
        sweep <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            wr(OFF_GLOBAL_CTRL, 32'h1);
            hold <= 1'b0;
            wr(OFF_STATUS_CONTROL, 32'h01);
            wr(OFF_GLOBAL_CTRL, 32'h0);
            hold <= 1'b1;
            fork
                wr(OFF_STATUS_CONTROL, 32'h0);
                begin
                    repeat (k) @(posedge clk);
                    ext <= 1'b1;
                    @(posedge clk);
                    ext <= 1'b0;
                end
            join
            repeat (3) @(posedge clk);
            if (vec.valid === 1'b1 && vec.addr === VEC_RESET) seen = 1'b1;
        end
        wr(OFF_GLOBAL_CTRL, 32'h1);
        hold <= 1'b0;
        wr(OFF_STATUS_CONTROL, 32'h0);
        sweep <= 1'b0;
        chk("race vector", {33'h0, seen}, 34'h1);
        stop_test();
    end
endmodule : tb_core_interrupt_status_vectoring
`default_nettype wire
